// ### lop_regs.sv
/*
 * indicator override and phy function control registers, apb slave,
 * pause resolution, self-test control and an event interrupt.
 * assumes: apb master per amba apb; all inputs synchronous to pclk;
 * strap input stable around reset release.
 */
`include "lop_defines.svh"

module lop_regs (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    output logic                  irq,
    input  wire lop_pkg::lop_ind_t ind_stretched,
    input  wire lop_pkg::lop_ind_t ind_raw,
    output lop_pkg::lop_ind_t     ind_out,
    input  wire lop_pkg::lop_an_t an,
    input  wire logic             auto_crossover_strap,
    output logic                  auto_crossover_enable,
    output logic                  force_pair_crossover,
    output logic                  pause_rx_en,
    output logic                  pause_tx_en,
    input  wire logic             selftest_error,
    output logic                  selftest_run,
    output logic                  selftest_pattern_select,
    output logic                  selftest_inject_error,
    output logic                  selftest_result
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    lop_pkg::lop_state_t s_r;
    lop_pkg::lop_state_t s_nxt;

    logic                 setup;
    logic                 access;
    logic                 wr_ok;
    logic                 hit_ind;
    logic                 hit_pfc;
    logic                 hit_sts;
    logic                 hit_mask;
    logic                 hit_any;
    logic [15:0]          wmask;
    logic [15:0]          wdata;
    logic                 lp;
    logic                 la;
    logic                 pp;
    logic                 pa;
    logic                 res_rx;
    logic                 res_tx;
    logic [`LOP_EV_W-1:0] ev;
    logic [15:0]          pfc_view;
    logic                 ovr_spd;
    logic                 ovr_lnk;
    logic                 ovr_act;
    lop_pkg::lop_ind_t    ind_norm;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign setup    = psel & ~penable;
    assign access   = psel & penable & s_r.pready;
    assign hit_ind  = (paddr == `LOP_ADDR_IND);
    assign hit_pfc  = (paddr == `LOP_ADDR_PFC);
    assign hit_sts  = (paddr == `LOP_ADDR_IRQ_STS);
    assign hit_mask = (paddr == `LOP_ADDR_IRQ_MASK);
    assign hit_any  = hit_ind | hit_pfc | hit_sts | hit_mask;
    assign wr_ok    = access & pwrite & hit_any;

    // only the two low byte lanes carry register bits
    assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wdata = pwdata[15:0];

    // ------------------------------------------------------------
    // pause resolution
    // ------------------------------------------------------------
    assign lp = an.local_pause[0];
    assign la = an.local_pause[1];
    assign pp = an.partner_pause[0];
    assign pa = an.partner_pause[1];

    // symmetric both ways, or asymmetric toward either end (rx: local receives, tx: local sends)
    assign res_rx = an.hcd_full_duplex
                  & ((lp & pp) | (lp & la & ~pp & pa));
    assign res_tx = an.hcd_full_duplex
                  & ((lp & pp) | (~lp & la & pp & pa));

    // ------------------------------------------------------------
    // events
    // ------------------------------------------------------------
    always_comb begin
        ev = '0;
        ev[`LOP_EV_FAIL]  = s_r.pfc[`LOP_PFC_RUN]
                          & s_r.pfc[`LOP_PFC_RESULT]
                          & selftest_error;
        ev[`LOP_EV_PAUSE] = (res_rx != s_r.pfc[`LOP_PFC_PAUSE_RX])
                          | (res_tx != s_r.pfc[`LOP_PFC_PAUSE_TX]);
    end

    // pause bits shown live so a read never lags the resolution
    always_comb begin
        pfc_view = s_r.pfc;
        pfc_view[`LOP_PFC_PAUSE_RX] = res_rx;
        pfc_view[`LOP_PFC_PAUSE_TX] = res_tx;
        pfc_view[6:0] = 7'h00;
    end

    // ------------------------------------------------------------
    // indicator path
    // ------------------------------------------------------------
    assign ind_norm = s_r.pfc[`LOP_PFC_BYPASS] ? ind_raw
                                               : ind_stretched;
    assign ovr_spd  = s_r.ind[`LOP_IND_SPD_EN];
    assign ovr_lnk  = s_r.ind[`LOP_IND_LNK_EN];
    assign ovr_act  = s_r.ind[`LOP_IND_ACT_EN];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;

        // strap caught on the first edge after release
        s_nxt.strap_done = 1'b1;
        if (!s_r.strap_done) begin
            s_nxt.pfc[`LOP_PFC_XOVER_EN] = auto_crossover_strap;
        end

        // single-cycle inject, cleared by hardware
        s_nxt.pfc[`LOP_PFC_INJECT] = 1'b0;

        // pause result kept for change detection and to drive pause_rx_en / pause_tx_en
        s_nxt.pfc[`LOP_PFC_PAUSE_RX] = res_rx;
        s_nxt.pfc[`LOP_PFC_PAUSE_TX] = res_tx;

        // self-test result: pass while running until an error
        if (!s_r.pfc[`LOP_PFC_RUN]) begin
            s_nxt.pfc[`LOP_PFC_RESULT] = 1'b0;
        end else if (selftest_error) begin
            s_nxt.pfc[`LOP_PFC_RESULT] = 1'b0;
        end

        // apb response: one wait-free access phase
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (setup) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = ~hit_any;
            s_nxt.prdata  = 32'h0000_0000;
            if (!pwrite) begin
                unique case (1'b1)
                    hit_ind:  s_nxt.prdata[`LOP_IND_W-1:0] = s_r.ind;
                    hit_pfc:  s_nxt.prdata[15:0] = pfc_view;
                    hit_sts:  s_nxt.prdata[`LOP_EV_W-1:0] = s_r.sts;
                    hit_mask: s_nxt.prdata[`LOP_EV_W-1:0] = s_r.mask;
                    default:  s_nxt.prdata = 32'h0000_0000;
                endcase
            end
        end
        if (access) begin
            s_nxt.pready  = 1'b0;
            s_nxt.pslverr = 1'b0;
        end

        // register writes
        if (wr_ok && hit_ind) begin
            s_nxt.ind = (s_r.ind & ~wmask[`LOP_IND_W-1:0])
                      | (wdata[`LOP_IND_W-1:0] & wmask[`LOP_IND_W-1:0]);
        end
        if (wr_ok && hit_pfc) begin
            s_nxt.pfc = (s_nxt.pfc & ~(wmask & `LOP_PFC_RW_MASK))
                      | (wdata & wmask & `LOP_PFC_RW_MASK);
            if (wmask[`LOP_PFC_INJECT] && wdata[`LOP_PFC_INJECT]) begin
                s_nxt.pfc[`LOP_PFC_INJECT] = 1'b1;
            end
            // a fresh start begins as pass
            if (wmask[`LOP_PFC_RUN] && wdata[`LOP_PFC_RUN]
                && !s_r.pfc[`LOP_PFC_RUN]) begin
                s_nxt.pfc[`LOP_PFC_RESULT] = 1'b1;
            end
            if (wmask[`LOP_PFC_RUN] && !wdata[`LOP_PFC_RUN]) begin
                s_nxt.pfc[`LOP_PFC_RESULT] = 1'b0;
            end
        end
        if (wr_ok && hit_mask) begin
            s_nxt.mask = (s_r.mask & ~wmask[`LOP_EV_W-1:0])
                       | (wdata[`LOP_EV_W-1:0] & wmask[`LOP_EV_W-1:0]);
        end

        // read clears only the bits returned; a new event still lands
        s_nxt.sts = s_r.sts;
        if (access && !pwrite && hit_sts) begin
            s_nxt.sts = s_r.sts & ~s_r.prdata[`LOP_EV_W-1:0];
        end
        s_nxt.sts = s_nxt.sts | ev;

        s_nxt.irq = |(s_nxt.sts & s_nxt.mask);

        // registered indicator outputs
        s_nxt.ind_out.speed = ovr_spd ? s_r.ind[`LOP_IND_SPD_VAL]
                                      : ind_norm.speed;
        s_nxt.ind_out.link  = ovr_lnk ? s_r.ind[`LOP_IND_LNK_VAL]
                                      : ind_norm.link;
        s_nxt.ind_out.act   = ovr_act ? s_r.ind[`LOP_IND_ACT_VAL]
                                      : ind_norm.act;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.ind        <= `LOP_IND_RST;
            s_r.pfc        <= `LOP_PFC_RST;
            s_r.sts        <= `LOP_EV_RST;
            s_r.mask       <= `LOP_EV_RST;
            s_r.strap_done <= 1'b0;
            s_r.prdata     <= 32'h0000_0000;
            s_r.pready     <= 1'b0;
            s_r.pslverr    <= 1'b0;
            s_r.ind_out    <= 3'h0;
            s_r.irq        <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------
    assign prdata  = s_r.prdata;
    assign pready  = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign irq     = s_r.irq;
    assign ind_out = s_r.ind_out;

    // crossover enable relies on software clearing it without autoneg
    assign auto_crossover_enable   = s_r.pfc[`LOP_PFC_XOVER_EN];
    assign force_pair_crossover    = s_r.pfc[`LOP_PFC_XOVER_FRC];
    assign pause_rx_en             = s_r.pfc[`LOP_PFC_PAUSE_RX];
    assign pause_tx_en             = s_r.pfc[`LOP_PFC_PAUSE_TX];
    assign selftest_run            = s_r.pfc[`LOP_PFC_RUN];
    assign selftest_pattern_select = s_r.pfc[`LOP_PFC_PATTERN];
    assign selftest_inject_error   = s_r.pfc[`LOP_PFC_INJECT];
    assign selftest_result         = s_r.pfc[`LOP_PFC_RESULT];

endmodule // lop_regs

// ### lop_defines.svh
/*
 * offsets, field positions and reset values of the indicator override
 * and phy function control registers.
 * assumes: included by bare name, definitions only.
 */
`ifndef LOP_DEFINES_SVH
`define LOP_DEFINES_SVH

// ----------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------
`define LOP_IDX_IND       12'h018
`define LOP_IDX_PFC       12'h019
`define LOP_ADDR_IND      (`LOP_IDX_IND * 12'h004)
`define LOP_ADDR_PFC      (`LOP_IDX_PFC * 12'h004)
`define LOP_ADDR_IRQ_STS  12'h080
`define LOP_ADDR_IRQ_MASK 12'h084

// ----------------------------------------------------------------
// indicator override fields
// ----------------------------------------------------------------
`define LOP_IND_SPD_EN  5
`define LOP_IND_LNK_EN  4
`define LOP_IND_ACT_EN  3
`define LOP_IND_SPD_VAL 2
`define LOP_IND_LNK_VAL 1
`define LOP_IND_ACT_VAL 0
`define LOP_IND_W       6
`define LOP_IND_RST     6'h00

// ----------------------------------------------------------------
// phy function control fields
// ----------------------------------------------------------------
`define LOP_PFC_XOVER_EN  15
`define LOP_PFC_XOVER_FRC 14
`define LOP_PFC_PAUSE_RX  13
`define LOP_PFC_PAUSE_TX  12
`define LOP_PFC_INJECT    11
`define LOP_PFC_PATTERN   10
`define LOP_PFC_RESULT    9
`define LOP_PFC_RUN       8
`define LOP_PFC_BYPASS    7
`define LOP_PFC_RW_MASK   16'hc580
`define LOP_PFC_RST       16'h0000

// ----------------------------------------------------------------
// interrupt status / mask fields
// ----------------------------------------------------------------
`define LOP_EV_FAIL  0
`define LOP_EV_PAUSE 1
`define LOP_EV_W     2
`define LOP_EV_RST   2'h0

`endif

// ### lop_pkg.sv
/*
 * types shared by the register block and its bench.
 * assumes: lop_defines.svh is on the include path.
 */
`include "lop_defines.svh"

package lop_pkg;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic speed;
        logic link;
        logic act;
    } lop_ind_t;

    // [1] asymmetric direction, [0] symmetric pause
    typedef struct packed {
        logic [1:0] local_pause;
        logic [1:0] partner_pause;
        logic       hcd_full_duplex;
    } lop_an_t;

    // ------------------------------------------------------------
    // whole state of the block
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`LOP_IND_W-1:0] ind;
        logic [15:0]           pfc;
        logic [`LOP_EV_W-1:0]  sts;
        logic [`LOP_EV_W-1:0]  mask;
        logic                  strap_done;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        lop_ind_t              ind_out;
        logic                  irq;
    } lop_state_t;

endpackage

// ### lop_regs_properties.sv
/* port-level checker for lop_regs, bound at the foot of this file.
 * assumes: lop_defines.svh on the include path; one clock, pclk. */
`include "lop_defines.svh"

module lop_regs_properties (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [3:0]       pstrb,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire lop_pkg::lop_an_t an,
    input wire logic             pause_rx_en,
    input wire logic             pause_tx_en,
    input wire logic             selftest_error,
    input wire logic             selftest_run,
    input wire logic             selftest_inject_error,
    input wire logic             selftest_result
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    function automatic logic f_rx(lop_pkg::lop_an_t a);
        return a.hcd_full_duplex & ((a.local_pause[0] & a.partner_pause[0]) |
               (&a.local_pause & a.partner_pause == 2'b10));
    endfunction
    function automatic logic f_tx(lop_pkg::lop_an_t a);
        return a.hcd_full_duplex & ((a.local_pause[0] & a.partner_pause[0]) |
               (a.local_pause == 2'b10 & &a.partner_pause));
    endfunction

    sequence s_setup; psel && !penable; endsequence
    sequence s_done; psel && penable && pready; endsequence
    sequence s_rd(a); s_done ##0 (!pwrite && paddr == a); endsequence
    sequence s_inject_wr; s_done ##0 (pwrite && paddr == `LOP_ADDR_PFC && pwdata[11] && pstrb[1]); endsequence

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_zero_wait; s_setup |=> s_done ##1 !pready; endproperty
    property p_unmapped_zero; s_done ##0 (pslverr && !pwrite) |-> prdata == 32'h0; endproperty
    property p_ind_reserved; s_rd(`LOP_ADDR_IND) |-> prdata[31:6] == 26'h0; endproperty
    // previous edge must be out of reset, else the lagging copy is still zero
    property p_pause_rx; $past(presetn) |-> pause_rx_en == f_rx($past(an)); endproperty
    property p_pause_tx; $past(presetn) |-> pause_tx_en == f_tx($past(an)); endproperty
    property p_read_pause;
        s_rd(`LOP_ADDR_PFC) |-> prdata[13:12] == {f_rx($past(an)), f_tx($past(an))};
    endproperty
    property p_inject_once; s_inject_wr |=> selftest_inject_error ##1 !selftest_inject_error; endproperty
    property p_stop_clears; !selftest_run && !$past(selftest_run) |-> !selftest_result; endproperty
    property p_error_fails; selftest_run && selftest_error |=> !selftest_result; endproperty

    a_zero_wait: assert property (p_zero_wait) else $error("access not one cycle");
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
    a_ind_reserved: assert property (p_ind_reserved) else $error("override upper bits not zero");
    a_pause_rx: assert property (p_pause_rx) else $error("pause receive wrong");
    a_pause_tx: assert property (p_pause_tx) else $error("pause transmit wrong");
    a_read_pause: assert property (p_read_pause) else $error("pause read bits wrong");
    a_inject_once: assert property (p_inject_once) else $error("inject not one pulse");
    a_stop_clears: assert property (p_stop_clears) else $error("result set while stopped");
    a_error_fails: assert property (p_error_fails) else $error("error did not fail result");
endmodule // lop_regs_properties

bind lop_regs lop_regs_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .an, .pause_rx_en, .pause_tx_en, .selftest_error,
    .selftest_run, .selftest_inject_error, .selftest_result);

// ### tb_lop_regs.sv
/* self-checking bench for lop_regs: apb master, random and corner stimulus.
 * assumes: lop_pkg compiled first; checker bound separately. */
`include "lop_defines.svh"

module tb_lop_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rdat, seed = 32'h6cad, v;
    logic [3:0]        pstrb;
    logic              pready, pslverr, irq, rerr, auto_crossover_strap, selftest_error;
    logic              auto_crossover_enable, force_pair_crossover, pause_rx_en, pause_tx_en;
    logic              selftest_run, selftest_pattern_select, selftest_inject_error, selftest_result;
    lop_pkg::lop_ind_t ind_stretched, ind_raw, ind_out;
    lop_pkg::lop_an_t  an;
    int                n_errors = 0, checks = 0, cyc = 0, i;

    lop_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .irq, .ind_stretched, .ind_raw, .ind_out, .an, .auto_crossover_strap,
        .auto_crossover_enable, .force_pair_crossover, .pause_rx_en, .pause_tx_en, .selftest_error,
        .selftest_run, .selftest_pattern_select, .selftest_inject_error, .selftest_result);

    always #10 pclk = ~pclk;
    // generous: the whole sequence needs well under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 5000) begin
            n_errors++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic f_rx(lop_pkg::lop_an_t a);
        return a.hcd_full_duplex & ((a.local_pause[0] & a.partner_pause[0]) |
               (&a.local_pause & a.partner_pause == 2'b10));
    endfunction
    function automatic logic f_tx(lop_pkg::lop_an_t a);
        return a.hcd_full_duplex & ((a.local_pause[0] & a.partner_pause[0]) |
               (a.local_pause == 2'b10 & &a.partner_pause));
    endfunction
    function automatic lop_pkg::lop_ind_t f_ind(logic [5:0] o, logic byp, lop_pkg::lop_ind_t s, r);
        lop_pkg::lop_ind_t n;
        n = byp ? r : s;
        return {o[5] ? o[2] : n.speed, o[4] ? o[1] : n.link, o[3] ? o[0] : n.act};
    endfunction
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // result lands in rdat/rerr; returns at the access edge
    // no wait limit here: only the cycle ceiling above ends a hung transfer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic summarize();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        paddr = 0; pwdata = 0; pstrb = 4'hf; ind_stretched = 0; ind_raw = 0; an = 0;
        selftest_error = 0; auto_crossover_strap = 1;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk); #1;
        chk("xover_strap", auto_crossover_enable, 1);
        apb(0, `LOP_ADDR_IND, 0); chk("ind_rst", rdat, 0);
        apb(0, `LOP_ADDR_PFC, 0); chk("pfc_rst", rdat, 32'h8000);
        for (i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            v = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : seed;
            apb(1, `LOP_ADDR_PFC, v[31:16] & 16'hc080);
            apb(1, `LOP_ADDR_IND, v[15:0]);
            ind_stretched <= seed[10:8]; ind_raw <= seed[13:11];
            repeat (2) @(posedge pclk); #1;
            chk("ind_out", ind_out, f_ind(v[5:0], v[23], ind_stretched, ind_raw));
            chk("xover", {auto_crossover_enable, force_pair_crossover}, v[31:30]);
            apb(0, `LOP_ADDR_IND, 0); chk("ind_rd", rdat, v[15:0] & 16'h3f);
            apb(0, `LOP_ADDR_PFC, 0); chk("pfc_rd", rdat & 32'hc080, v[31:16] & 16'hc080);
        end
        // lane 1 only: override bits sit in lane 0 and must stay
        pstrb <= 4'h2;
        apb(1, `LOP_ADDR_IND, 32'h0);
        pstrb <= 4'hf;
        apb(0, `LOP_ADDR_IND, 0); chk("ind_strb", rdat, v[15:0] & 16'h3f);
        for (i = 0; i < 32; i++) begin
            @(posedge pclk); an <= lop_pkg::lop_an_t'(i[4:0]);
            repeat (2) @(posedge pclk); #1;
            chk("pause_out", {pause_rx_en, pause_tx_en}, {f_rx(an), f_tx(an)});
            apb(0, `LOP_ADDR_PFC, 0); chk("pause_rd", rdat[13:12], {f_rx(an), f_tx(an)});
        end
        apb(0, `LOP_ADDR_IRQ_STS, 0);
        an <= 0;
        repeat (3) @(posedge pclk); #1;
        chk("irq_masked", irq, 0);
        apb(1, `LOP_ADDR_IRQ_MASK, 3);
        repeat (2) @(posedge pclk); #1;
        chk("irq_on", irq, 1);
        apb(0, `LOP_ADDR_IRQ_STS, 0); chk("sts_pause", rdat, 32'h2);
        repeat (2) @(posedge pclk); #1;
        chk("irq_clr", irq, 0);
        apb(0, 12'h0f0, 0); chk("unmapped_rd", rdat, 32'h0);
        chk("unmapped_rd_err", rerr, 1);
        apb(1, 12'h0f0, 32'hffff_ffff); chk("unmapped_wr", rerr, 1);
        for (i = 0; i < 2; i++) begin
            apb(1, `LOP_ADDR_PFC, 32'h0100 | (i << 10)); #1;
            chk("st_on", {selftest_run, selftest_pattern_select, selftest_result}, {2'b1, i[0], 1'b1});
            apb(1, `LOP_ADDR_PFC, 32'h0900 | (i << 10)); #1;
            chk("inject_hi", selftest_inject_error, 1);
            @(posedge pclk); #1;
            chk("inject_lo", selftest_inject_error, 0);
            apb(0, `LOP_ADDR_PFC, 0); chk("st_rd", rdat[11:8], {1'b0, i[0], 2'b11});
            selftest_error <= 1;
            @(posedge pclk); selftest_error <= 0;
            @(posedge pclk); #1;
            chk("st_fail", {selftest_result, irq}, 2'b01);
            apb(0, `LOP_ADDR_IRQ_STS, 0); chk("sts_fail", rdat, 32'h1);
            apb(1, `LOP_ADDR_PFC, 0);
            @(posedge pclk); #1;
            chk("st_off", {selftest_run, selftest_result}, 2'b00);
        end
        @(posedge pclk);
        presetn <= 0; auto_crossover_strap <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk); #1;
        chk("xover_strap0", auto_crossover_enable, 0);
        summarize();
    end
endmodule // tb_lop_regs
